// ===== core/fdt_interval_cnt.sv
`timescale 1ns/1ps
module fdt_interval_cnt (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     run,
  input  wire logic                     tick,
  input  wire logic [2:0]               code,
  output logic                          dec_due,
  output logic                          inc_due
);
  import fdt_pkg::*;

  logic [fdt_pkg::CNT_W-1:0] cnt_q;
  logic [fdt_pkg::CNT_W-1:0] dec_len;
  logic [fdt_pkg::CNT_W-1:0] inc_len;

  // ----------------------------------------------------------------
  // doubling per code step
  // ----------------------------------------------------------------
  assign dec_len = DEC_BASE_CYCLES << code;
  assign inc_len = INC_BASE_CYCLES << code;

  always_ff @(posedge clk) begin
    if (!nrst || !run) begin
      cnt_q <= '0;
    end else if (tick) begin
      if (cnt_q == inc_len - 11'h001) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 11'h001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dec_due <= 1'b0;
      inc_due <= 1'b0;
    end else begin
      dec_due <= run && tick && ((cnt_q == dec_len - 11'h001) ||
                 (cnt_q == inc_len - 11'h001));
      inc_due <= run && tick && (cnt_q == inc_len - 11'h001);
    end
  end

endmodule

// ===== core/fdt_regs.sv
`timescale 1ns/1ps
module fdt_regs (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire fdt_pkg::fdt_bus_type  bus,
  output logic [7:0]                 rdata,
  input  wire logic                  config_lock,
  input  wire logic                  auto_mode,
  input  wire logic                  monitor_tick,
  input  wire logic                  thermal_alarm_pin,
  input  wire fdt_pkg::fdt_temps_type temps,
  input  wire logic [2:0]            auto_duty_valid,
  input  wire logic [23:0]           auto_duty,
  input  wire logic [2:0]            fan_startup,
  output logic [23:0]                pwm_duty,
  output logic [23:0]                target_temp,
  output logic [2:0]                 dyn_adjust_en,
  output logic [2:0]                 start_temp_dec,
  output logic [2:0]                 start_temp_inc
);
  import fdt_pkg::*;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0]  duty_q   [NUM_CH];
  logic [7:0]  target_q [NUM_CH];
  logic [7:0]  ctrl_a_q;
  logic [7:0]  ctrl_b_q;
  logic        alarm_q;
  logic        alarm_rise;
  logic [2:0]  capture_en;
  logic [2:0]  interval_code [NUM_CH];
  logic [2:0]  dec_due;
  logic [2:0]  inc_due;
  logic [7:0]  cur_temp [NUM_CH];
  fdt_adj_type adj_state_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [7:0] duty_ofs(input int ch);
    duty_ofs = FAN1_DUTY_NOW_OFS + 8'(ch);
  endfunction

  function automatic logic [7:0] target_ofs(input int ch);
    target_ofs = REMOTE1_TARGET_OFS + 8'(ch);
  endfunction

  assign cur_temp[CH_REMOTE1] = temps.remote1;
  assign cur_temp[CH_LOCAL]   = temps.local_t;
  assign cur_temp[CH_REMOTE2] = temps.remote2;

  assign capture_en = ctrl_a_q[CTRL_A_R2_CAPTURE:CTRL_A_R1_CAPTURE];
  assign alarm_rise = thermal_alarm_pin && !alarm_q;

  // ----------------------------------------------------------------
  // interval codes
  // ----------------------------------------------------------------
  assign interval_code[CH_REMOTE1] = ctrl_b_q[CTRL_B_R1_LSB +: 3];
  assign interval_code[CH_LOCAL]   = ctrl_b_q[CTRL_B_LOC_LSB +: 3];
  assign interval_code[CH_REMOTE2] = {ctrl_a_q[CTRL_A_R2_INTERVAL_MSB],
                                      ctrl_b_q[CTRL_B_R2_LSB +: 2]};

  // ----------------------------------------------------------------
  // alarm edge
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      alarm_q <= 1'b0;
    end else begin
      alarm_q <= thermal_alarm_pin;
    end
  end

  // ----------------------------------------------------------------
  // per-channel duty, target, interval
  // ----------------------------------------------------------------
  generate
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      always_ff @(posedge clk) begin
        if (!nrst) begin
          duty_q[ch] <= DUTY_RESET;
        end else if (auto_mode) begin
          if (auto_duty_valid[ch]) begin
            duty_q[ch] <= auto_duty[ch*8 +: 8];
          end
        end else if (bus.wr && hit(bus.addr, duty_ofs(ch))) begin
          duty_q[ch] <= bus.wdata;
        end
      end

      always_ff @(posedge clk) begin
        if (!nrst) begin
          target_q[ch] <= TARGET_RESET;
        end else if (alarm_rise && capture_en[ch]) begin
          target_q[ch] <= cur_temp[ch];
        end else if (bus.wr && !config_lock && hit(bus.addr, target_ofs(ch))) begin
          target_q[ch] <= bus.wdata;
        end
      end

      fdt_interval_cnt u_cnt (
        .clk     (clk),
        .nrst    (nrst),
        .run     (dyn_adjust_en[ch]),
        .tick    (monitor_tick),
        .code    (interval_code[ch]),
        .dec_due (dec_due[ch]),
        .inc_due (inc_due[ch])
      );

      always_ff @(posedge clk) begin
        if (!nrst) begin
          pwm_duty[ch*8 +: 8]    <= DUTY_RESET;
          target_temp[ch*8 +: 8] <= TARGET_RESET;
        end else begin
          pwm_duty[ch*8 +: 8]    <= duty_q[ch];
          target_temp[ch*8 +: 8] <= target_q[ch];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // dynamic control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_a_q <= DYN_CTRL_RESET;
    end else if (bus.wr && !config_lock && hit(bus.addr, DYN_CTRL_A_OFS)) begin
      ctrl_a_q <= bus.wdata & CTRL_A_WR_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_b_q <= DYN_CTRL_RESET;
    end else if (bus.wr && hit(bus.addr, DYN_CTRL_B_OFS)) begin
      ctrl_b_q <= bus.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dyn_adjust_en <= '0;
    end else begin
      dyn_adjust_en[CH_REMOTE1] <= ctrl_a_q[CTRL_A_R1_DYN];
      dyn_adjust_en[CH_LOCAL]   <= ctrl_a_q[CTRL_A_LOC_DYN];
      dyn_adjust_en[CH_REMOTE2] <= ctrl_a_q[CTRL_A_R2_DYN];
    end
  end

  // ----------------------------------------------------------------
  // adjustment pacing pulses
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      adj_state_q <= FDT_ADJ_IDLE;
    end else begin
      case (adj_state_q)
        FDT_ADJ_IDLE: adj_state_q <= (|dyn_adjust_en) ? FDT_ADJ_WAIT : FDT_ADJ_IDLE;
        FDT_ADJ_WAIT: adj_state_q <= (|dyn_adjust_en) ?
                                     ((|dec_due) ? FDT_ADJ_FIRE : FDT_ADJ_WAIT) : FDT_ADJ_IDLE;
        FDT_ADJ_FIRE: adj_state_q <= (|dyn_adjust_en) ? FDT_ADJ_WAIT : FDT_ADJ_IDLE;
        default:      adj_state_q <= FDT_ADJ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      start_temp_dec <= '0;
      start_temp_inc <= '0;
    end else begin
      start_temp_dec <= dec_due & dyn_adjust_en;
      start_temp_inc <= inc_due & dyn_adjust_en;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata <= READ_ZERO;
    end else if (bus.rd) begin
      rdata <= READ_ZERO;
      for (int ch = 0; ch < NUM_CH; ch++) begin
        if (hit(bus.addr, duty_ofs(ch))) begin
          rdata <= fan_startup[ch] ? DUTY_ZERO : duty_q[ch];
        end
        if (hit(bus.addr, target_ofs(ch))) begin
          rdata <= target_q[ch];
        end
      end
      if (hit(bus.addr, DYN_CTRL_A_OFS)) begin
        rdata <= ctrl_a_q;
      end
      if (hit(bus.addr, DYN_CTRL_B_OFS)) begin
        rdata <= ctrl_b_q;
      end
      if (hit(bus.addr, STATUS_OFS)) begin
        rdata <= {3'h0, adj_state_q != FDT_ADJ_IDLE, config_lock, dyn_adjust_en};
      end
    end else begin
      rdata <= READ_ZERO;
    end
  end

endmodule

// ===== shared/fdt_pkg.sv
package fdt_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] FAN1_DUTY_NOW_OFS      = 8'h30;
  localparam logic [7:0] FAN2_DUTY_NOW_OFS      = 8'h31;
  localparam logic [7:0] FAN3_DUTY_NOW_OFS      = 8'h32;
  localparam logic [7:0] REMOTE1_TARGET_OFS     = 8'h33;
  localparam logic [7:0] LOCAL_TARGET_OFS       = 8'h34;
  localparam logic [7:0] REMOTE2_TARGET_OFS     = 8'h35;
  localparam logic [7:0] DYN_CTRL_A_OFS         = 8'h36;
  localparam logic [7:0] DYN_CTRL_B_OFS         = 8'h37;
  localparam logic [7:0] STATUS_OFS             = 8'h38;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DUTY_RESET             = 8'hff;
  localparam logic [7:0] TARGET_RESET           = 8'h64;
  localparam logic [7:0] DYN_CTRL_RESET         = 8'h00;
  localparam logic [7:0] DUTY_ZERO              = 8'h00;
  localparam logic [7:0] READ_ZERO              = 8'h00;

  // ----------------------------------------------------------------
  // control a field positions
  // ----------------------------------------------------------------
  localparam int CTRL_A_R2_INTERVAL_MSB = 0;
  localparam int CTRL_A_RESERVED        = 1;
  localparam int CTRL_A_R1_CAPTURE      = 2;
  localparam int CTRL_A_LOC_CAPTURE     = 3;
  localparam int CTRL_A_R2_CAPTURE      = 4;
  localparam int CTRL_A_R1_DYN          = 5;
  localparam int CTRL_A_LOC_DYN         = 6;
  localparam int CTRL_A_R2_DYN          = 7;
  localparam logic [7:0] CTRL_A_WR_MASK = 8'hfd;

  // control b: remote1 code [2:0], local code [5:3], remote2 low [7:6]
  localparam int CTRL_B_R1_LSB  = 0;
  localparam int CTRL_B_LOC_LSB = 3;
  localparam int CTRL_B_R2_LSB  = 6;

  // ----------------------------------------------------------------
  // channels and interval timing
  // ----------------------------------------------------------------
  localparam int NUM_CH       = 3;
  localparam int CH_REMOTE1   = 0;
  localparam int CH_LOCAL     = 1;
  localparam int CH_REMOTE2   = 2;
  localparam int CNT_W        = 11;
  localparam logic [CNT_W-1:0] DEC_BASE_CYCLES = 11'h004;
  localparam logic [CNT_W-1:0] INC_BASE_CYCLES = 11'h008;

  typedef enum logic [1:0] {FDT_ADJ_IDLE, FDT_ADJ_WAIT, FDT_ADJ_FIRE} fdt_adj_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fdt_bus_type;

  typedef struct packed {
    logic [7:0] remote1;
    logic [7:0] local_t;
    logic [7:0] remote2;
  } fdt_temps_type;

endpackage

// ===== sim/fdt_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// management host model
// ----------------------------------------
module fdt_host (
  input  wire logic            clk,
  output fdt_pkg::fdt_bus_type bus,
  input  wire logic [7:0]      rdata
);
  import fdt_pkg::*;
  initial bus = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
    d = rdata;
  endtask
endmodule

// ===== sim/fdt_regs_properties.sv
`timescale 1ns/1ps
// ----------------------------------------
// register bank checker
// ----------------------------------------
module fdt_regs_chk (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire fdt_pkg::fdt_bus_type bus,
  input  wire logic [7:0]           rdata,
  input  wire logic                 config_lock,
  input  wire logic                 auto_mode,
  input  wire logic                 thermal_alarm_pin,
  input  wire logic [2:0]           fan_startup,
  input  wire logic [23:0]          pwm_duty,
  input  wire logic [23:0]          target_temp,
  input  wire logic [2:0]           dyn_adjust_en,
  input  wire logic [2:0]           start_temp_dec,
  input  wire logic [2:0]           start_temp_inc
);
  import fdt_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  reset_vals_a: assert property ($rose(nrst) |->
    pwm_duty == 24'hffffff && target_temp == 24'h646464) else $error("reset values wrong");
  startup_read_a: assert property (bus.rd && bus.addr == 8'h30 && fan_startup[0] |=>
    rdata == 8'h00) else $error("startup duty not zero");
  sw_duty_a: assert property (bus.wr && !auto_mode && bus.addr == 8'h30 ##1 !bus.wr |=>
    pwm_duty[7:0] == $past(bus.wdata, 2)) else $error("duty write not applied");
  lock_target_a: assert property ((config_lock && !thermal_alarm_pin) [*4] |->
    $stable(target_temp)) else $error("locked target changed");
  lock_dyn_a: assert property (config_lock [*3] |-> $stable(dyn_adjust_en))
    else $error("locked enables changed");
  dyn_follow_a: assert property (!$stable(dyn_adjust_en) |->
    $past(bus.wr && bus.addr == 8'h36) || $past(bus.wr && bus.addr == 8'h36, 2))
    else $error("enables changed without write");
  dec_enabled_a: assert property ((start_temp_dec &
    ~($past(dyn_adjust_en) | $past(dyn_adjust_en, 2))) == 3'h0) else $error("pulse while off");
  inc_with_dec_a: assert property ((start_temp_inc & ~start_temp_dec) == 3'h0)
    else $error("increase step off its decrease step");
  cover property ($rose(thermal_alarm_pin) && target_temp != 24'h646464);
  cover property (start_temp_inc[2]);
  cover property (bus.wr && config_lock);
endmodule

bind fdt_regs fdt_regs_chk u_fdt_regs_chk (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata),
  .config_lock(config_lock), .auto_mode(auto_mode), .thermal_alarm_pin(thermal_alarm_pin),
  .fan_startup(fan_startup), .pwm_duty(pwm_duty), .target_temp(target_temp),
  .dyn_adjust_en(dyn_adjust_en), .start_temp_dec(start_temp_dec),
  .start_temp_inc(start_temp_inc));

// ===== sim/tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------
// register bank testbench
// ----------------------------------------
module tb_top;
  import fdt_pkg::*;
  fdt_bus_type   bus;
  fdt_temps_type temps;
  logic          clk, nrst, config_lock, auto_mode, monitor_tick, thermal_alarm_pin;
  logic [2:0]    auto_duty_valid, fan_startup, dyn_adjust_en, start_temp_dec, start_temp_inc;
  logic [7:0]    rdata, rv;
  logic [23:0]   auto_duty, pwm_duty, target_temp, exp_t;
  int            err_total, checks_done, n_dec[3], n_inc[3];

  fdt_regs u_fdt_regs (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata),
    .config_lock(config_lock), .auto_mode(auto_mode), .monitor_tick(monitor_tick),
    .thermal_alarm_pin(thermal_alarm_pin), .temps(temps), .auto_duty_valid(auto_duty_valid),
    .auto_duty(auto_duty), .fan_startup(fan_startup), .pwm_duty(pwm_duty),
    .target_temp(target_temp), .dyn_adjust_en(dyn_adjust_en),
    .start_temp_dec(start_temp_dec), .start_temp_inc(start_temp_inc));
  fdt_host u_fdt_host (.clk(clk), .bus(bus), .rdata(rdata));

  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      n_dec[i] += start_temp_dec[i];
      n_inc[i] += start_temp_inc[i];
    end
  end

  task chk(input string n, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] exp);
    u_fdt_host.rd(a, rv);
    chk($sformatf("reg %h", a), rv, exp);
  endtask
  task test_done;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task ticks(input int n);
    n_dec = '{0, 0, 0};
    n_inc = '{0, 0, 0};
    repeat (n) begin
      monitor_tick <= 1;
      @(posedge clk);
      monitor_tick <= 0;
      @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask

  task t_reset;
    for (int a = 0; a < 8; a++) rdchk(8'(8'h30 + a), a < 3 ? 8'hff : a < 6 ? 8'h64 : 8'h00);
    rdchk(8'h50, 8'h00);
    chk("pwm", pwm_duty, 24'hffffff);
  endtask
  task t_sw;
    for (int i = 0; i < 3; i++) begin
      u_fdt_host.wr(8'(8'h30 + i), 8'(8'hff - 8'h7f * i));
      @(posedge clk);
      chk("pwm", pwm_duty[8*i+:8], 8'(8'hff - 8'h7f * i));
      rdchk(8'(8'h30 + i), 8'(8'hff - 8'h7f * i));
    end
    fan_startup <= 3'h1;
    rdchk(8'h30, 8'h00);
    chk("pwm startup", pwm_duty[7:0], 8'hff);
    fan_startup <= 3'h0;
  endtask
  task t_auto;
    auto_mode <= 1;
    auto_duty <= 24'h123456;
    auto_duty_valid <= 3'h7;
    @(posedge clk);
    auto_duty_valid <= 3'h0;
    u_fdt_host.wr(8'h30, 8'h99);
    @(posedge clk);
    chk("auto pwm", pwm_duty, 24'h123456);
    rdchk(8'h30, 8'h56);
    auto_mode <= 0;
  endtask
  task t_ctrl;
    u_fdt_host.wr(8'h36, 8'hff);
    rdchk(8'h36, 8'hfd);
    chk("dyn en", dyn_adjust_en, 3'h7);
    rdchk(8'h38, 8'h17);
    u_fdt_host.wr(8'h36, 8'h00);
    @(posedge clk);
    chk("dyn en", dyn_adjust_en, 3'h0);
  endtask
  task t_capture;
    temps <= '{remote1: 8'h41, local_t: 8'h52, remote2: 8'h63};
    exp_t = 24'h646464;
    for (int k = -1; k < 3; k++) begin
      u_fdt_host.wr(8'h36, k < 0 ? 8'h00 : 8'(8'h04 << k));
      thermal_alarm_pin <= 1;
      repeat (3) @(posedge clk);
      thermal_alarm_pin <= 0;
      if (k >= 0) exp_t[8*k+:8] = 8'(8'h41 + 8'h11 * k);
      repeat (2) @(posedge clk);
      chk("targets", target_temp, exp_t);
      if (k >= 0) rdchk(8'(8'h33 + k), exp_t[8*k+:8]);
    end
  endtask
  task t_lock;
    u_fdt_host.wr(8'h33, 8'h20);
    config_lock <= 1;
    u_fdt_host.wr(8'h33, 8'h30);
    u_fdt_host.wr(8'h36, 8'he0);
    rdchk(8'h33, 8'h20);
    rdchk(8'h36, 8'h10);
    rdchk(8'h38, 8'h08);
    config_lock <= 0;
  endtask
  task t_interval;
    u_fdt_host.wr(8'h37, 8'h08);
    u_fdt_host.wr(8'h36, 8'h61);
    ticks(32);
    chk("dec", {8'(n_dec[2]), 8'(n_dec[1]), 8'(n_dec[0])}, 24'h000408);
    chk("inc", {8'(n_inc[2]), 8'(n_inc[1]), 8'(n_inc[0])}, 24'h000204);
    u_fdt_host.wr(8'h37, 8'h00);
    u_fdt_host.wr(8'h36, 8'h81);
    ticks(128);
    chk("dec", {8'(n_dec[2]), 8'(n_dec[1]), 8'(n_dec[0])}, 24'h020000);
    chk("inc", {8'(n_inc[2]), 8'(n_inc[1]), 8'(n_inc[0])}, 24'h010000);
  endtask

  initial begin
    nrst = 0;
    config_lock = 0;
    auto_mode = 0;
    monitor_tick = 0;
    thermal_alarm_pin = 0;
    temps = '0;
    auto_duty_valid = 3'h0;
    auto_duty = 24'h0;
    fan_startup = 3'h0;
    err_total = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    t_reset;
    t_sw;
    t_auto;
    t_ctrl;
    t_capture;
    t_lock;
    t_interval;
    test_done;
  end

  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    test_done;
  end
endmodule
